// ===== rtl/hblap_pkg.sv
package hblap_pkg;
    localparam int DATA_W = 32;
    localparam int FIFO_DEPTH = 8;
    localparam int IREG_W = 16;
    localparam int LANES = 4;
    localparam logic [1:0] ADR_DATA = 2'h0;
    localparam logic [1:0] ADR_IADDR = 2'h1;
    localparam logic [1:0] ADR_IDATA = 2'h2;
    localparam int TOP_LANE = 3;
    localparam int HALF_LANE = 1;
    localparam logic [31:0] WORD_RST = 32'h0000_0000;
    localparam logic [15:0] IREG_RST = 16'h0000;
    localparam logic [15:0] IREG_STEP = 16'h0001;
endpackage

// ===== rtl/hblap_fifo_if.sv
`timescale 1ns/1ps
interface hblap_fifo_if #(parameter int W = hblap_pkg::DATA_W);
    logic wr_valid;
    logic wr_ready;
    logic [W-1:0] wr_data;
    logic rd_valid;
    logic rd_ready;
    logic [W-1:0] rd_data;
    modport store (input wr_valid, input wr_data, output wr_ready, output rd_valid, input rd_ready, output rd_data);
    modport user (output wr_valid, output wr_data, input wr_ready, input rd_valid, output rd_ready, input rd_data);
endinterface

// ===== rtl/hblap_fifo.sv
`timescale 1ns/1ps
module hblap_fifo #(
    parameter int W = hblap_pkg::DATA_W,
    parameter int D = hblap_pkg::FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst_n,
    hblap_fifo_if.store f
);
    localparam int PW = $clog2(D);
    localparam int CW = $clog2(D + 1);

    logic [W-1:0] mem_reg [D];
    logic [W-1:0] mem_next [D];
    logic [PW-1:0] wp_reg, wp_next, rp_reg, rp_next;
    logic [CW-1:0] cnt_reg, cnt_next;
    logic [W-1:0] head_reg, head_next;
    logic do_wr, do_rd;

    function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
        ptr_inc = (p == PW'(D - 1)) ? '0 : p + PW'(1);
    endfunction

    assign f.wr_ready = (cnt_reg != CW'(D));
    assign f.rd_valid = (cnt_reg != '0);
    assign f.rd_data = head_reg;

    always_comb begin
        do_wr = f.wr_valid && f.wr_ready;
        do_rd = f.rd_ready && f.rd_valid;
        mem_next = mem_reg;
        wp_next = wp_reg;
        rp_next = rp_reg;
        if (do_wr) begin
            mem_next[wp_reg] = f.wr_data;
            wp_next = ptr_inc(wp_reg);
        end
        if (do_rd) begin
            rp_next = ptr_inc(rp_reg);
        end
        cnt_next = cnt_reg + CW'(do_wr) - CW'(do_rd);
        head_next = mem_next[rp_next];
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < D; i++) begin
                mem_reg[i] <= '0;
            end
            wp_reg <= '0;
            rp_reg <= '0;
            cnt_reg <= '0;
            head_reg <= '0;
        end else begin
            mem_reg <= mem_next;
            wp_reg <= wp_next;
            rp_reg <= rp_next;
            cnt_reg <= cnt_next;
            head_reg <= head_next;
        end
    end
endmodule // hblap_fifo

// ===== rtl/hblap_host_port.sv
`timescale 1ns/1ps
module hblap_host_port (
    input wire logic MCLK,
    input wire logic NRST,
    input wire logic CS_N,
    input wire logic RD_N,
    input wire logic WR_N,
    input wire logic [3:0] BE_N,
    input wire logic [1:0] ADR,
    input wire logic [31:0] DATA_I,
    output logic [31:0] DATA_O,
    output logic DATA_OE,
    output logic ACK_N,
    input wire logic ENCODE,
    output logic FIFO_FULL,
    output logic FIFO_EMPTY,
    input wire logic [31:0] CORE_TX_DATA,
    input wire logic CORE_TX_VALID,
    output logic CORE_TX_READY,
    output logic [31:0] CORE_RX_DATA,
    output logic CORE_RX_VALID,
    input wire logic CORE_RX_READY,
    output logic [15:0] IREG_ADDR,
    output logic [15:0] IREG_WDATA,
    output logic [1:0] IREG_WSTRB,
    output logic IREG_WE,
    input wire logic [15:0] IREG_RDATA
);
    hblap_fifo_if #(.W(hblap_pkg::DATA_W)) fifo_bus ();

    hblap_fifo #(.W(hblap_pkg::DATA_W), .D(hblap_pkg::FIFO_DEPTH)) u_fifo (
        .clk(MCLK),
        .rst_n(NRST),
        .f(fifo_bus)
    );

    logic sel, rd_act, wr_act, wr_rise, top_rel, half_rel, host_push, host_pop, hold;
    logic [3:0] byte_lane_selects, lane_rel;
    logic [3:0] lanes_reg, lanes_next;
    logic wr_reg, wr_next;
    logic [1:0] adr_reg, adr_next;
    logic [31:0] asm_reg, asm_next;
    logic [15:0] ireg_idx_reg, ireg_idx_next;
    logic [15:0] ireg_stage_reg, ireg_stage_next;
    logic [1:0] ireg_strb_reg, ireg_strb_next;
    logic [15:0] iaddr_reg, iaddr_next;
    logic [15:0] iwdata_reg, iwdata_next;
    logic [1:0] iwstrb_reg, iwstrb_next;
    logic iwe_reg, iwe_next;
    logic [31:0] dout_reg, dout_next;
    logic rd_reg, rd_next;
    logic vld_reg, vld_next;
    logic [31:0] idx_m, stage_m;
    logic [1:0] strb_m;

    // Byte-lane merge, lane 0 lowest
    function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw,
                                               input logic [3:0] en);
        lane_merge = old;
        for (int k = 0; k < hblap_pkg::LANES; k++) begin
            if (en[k]) begin
                lane_merge[8*k +: 8] = nw[8*k +: 8];
            end
        end
    endfunction

    // Host qualification
    assign sel = !CS_N;
    assign byte_lane_selects = sel ? ~BE_N : 4'h0;
    assign rd_act = sel && !RD_N;
    assign wr_act = sel && !WR_N;
    assign wr_rise = wr_reg && WR_N;
    assign lane_rel = lanes_reg & ~byte_lane_selects;
    assign top_rel = lane_rel[hblap_pkg::TOP_LANE] && (adr_reg == hblap_pkg::ADR_DATA);
    assign half_rel = lane_rel[hblap_pkg::HALF_LANE] && (adr_reg == hblap_pkg::ADR_IDATA);
    assign host_push = top_rel && !ENCODE;
    assign host_pop = top_rel && ENCODE;

    // FIFO steering by direction
    assign fifo_bus.wr_valid = ENCODE ? CORE_TX_VALID : host_push;
    assign fifo_bus.wr_data = ENCODE ? CORE_TX_DATA : asm_next;
    assign fifo_bus.rd_ready = ENCODE ? host_pop : CORE_RX_READY;
    assign CORE_TX_READY = ENCODE && fifo_bus.wr_ready;
    assign CORE_RX_VALID = !ENCODE && fifo_bus.rd_valid;
    assign CORE_RX_DATA = fifo_bus.rd_data;
    assign FIFO_FULL = !fifo_bus.wr_ready;
    assign FIFO_EMPTY = !fifo_bus.rd_valid;

    // Bus drive and acknowledge
    // Read data needs one registered cycle before acknowledge
    assign hold = (ADR == hblap_pkg::ADR_DATA) &&
                  (ENCODE ? (!RD_N && !(fifo_bus.rd_valid && vld_reg)) : (!WR_N && !fifo_bus.wr_ready));
    assign ACK_N = !(((rd_act && rd_reg) || wr_act) && !hold);
    assign DATA_OE = rd_act;
    assign DATA_O = dout_reg;
    assign IREG_ADDR = iaddr_reg;
    assign IREG_WDATA = iwdata_reg;
    assign IREG_WSTRB = iwstrb_reg;
    assign IREG_WE = iwe_reg;

    always_comb begin
        lanes_next = byte_lane_selects;
        wr_next = wr_act;
        rd_next = rd_act;
        vld_next = fifo_bus.rd_valid;
        idx_m = lane_merge({16'h0000, ireg_idx_reg}, DATA_I, lanes_reg);
        stage_m = lane_merge({16'h0000, ireg_stage_reg}, DATA_I, lanes_reg);
        adr_next = sel ? ADR : adr_reg;
        asm_next = asm_reg;
        ireg_idx_next = ireg_idx_reg;
        ireg_stage_next = ireg_stage_reg;
        ireg_strb_next = ireg_strb_reg;
        iwdata_next = iwdata_reg;
        iwstrb_next = iwstrb_reg;
        iwe_next = 1'b0;
        if (wr_rise) begin
            unique case (adr_reg)
                hblap_pkg::ADR_DATA: asm_next = lane_merge(asm_reg, DATA_I, lanes_reg);
                hblap_pkg::ADR_IADDR: ireg_idx_next = idx_m[15:0];
                hblap_pkg::ADR_IDATA: begin
                    ireg_stage_next = stage_m[15:0];
                    ireg_strb_next = ireg_strb_reg | lanes_reg[1:0];
                end
                default: ;
            endcase
        end
        // Strobes gathered so far, kept before the step clears them
        strb_m = ireg_strb_next;
        if (half_rel) begin
            ireg_idx_next = ireg_idx_reg + hblap_pkg::IREG_STEP;
            ireg_strb_next = 2'h0;
            if (strb_m != 2'h0) begin
                iwe_next = 1'b1;
                iwdata_next = ireg_stage_next;
                iwstrb_next = strb_m;
            end
        end
        iaddr_next = iwe_next ? ireg_idx_reg : ireg_idx_next;
        unique case (ADR)
            hblap_pkg::ADR_DATA: dout_next = ENCODE ? fifo_bus.rd_data : asm_reg;
            hblap_pkg::ADR_IADDR: dout_next = {16'h0000, ireg_idx_reg};
            hblap_pkg::ADR_IDATA: dout_next = {16'h0000, IREG_RDATA};
            default: dout_next = hblap_pkg::WORD_RST;
        endcase
    end

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            lanes_reg <= 4'h0;
            wr_reg <= 1'b0;
            rd_reg <= 1'b0;
            vld_reg <= 1'b0;
            adr_reg <= hblap_pkg::ADR_DATA;
            asm_reg <= hblap_pkg::WORD_RST;
            ireg_idx_reg <= hblap_pkg::IREG_RST;
            ireg_stage_reg <= hblap_pkg::IREG_RST;
            ireg_strb_reg <= 2'h0;
            iaddr_reg <= hblap_pkg::IREG_RST;
            iwdata_reg <= hblap_pkg::IREG_RST;
            iwstrb_reg <= 2'h0;
            iwe_reg <= 1'b0;
            dout_reg <= hblap_pkg::WORD_RST;
        end else begin
            lanes_reg <= lanes_next;
            wr_reg <= wr_next;
            rd_reg <= rd_next;
            vld_reg <= vld_next;
            adr_reg <= adr_next;
            asm_reg <= asm_next;
            ireg_idx_reg <= ireg_idx_next;
            ireg_stage_reg <= ireg_stage_next;
            ireg_strb_reg <= ireg_strb_next;
            iaddr_reg <= iaddr_next;
            iwdata_reg <= iwdata_next;
            iwstrb_reg <= iwstrb_next;
            iwe_reg <= iwe_next;
            dout_reg <= dout_next;
        end
    end

    // Checks
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!NRST);

    AST_BUS_RELEASED: assert property (CS_N |-> !DATA_OE)
        else $error("Data bus driven while deselected");
    AST_READ_DRIVE: assert property ((!CS_N && !RD_N) |-> DATA_OE ##1 (!CS_N && !RD_N && $stable(ADR)) |->
                                     DATA_OE)
        else $error("Read strobe low without bus drive");
    AST_NO_ACK_DESEL: assert property (CS_N |-> ACK_N)
        else $error("Acknowledge while deselected");
    AST_PUSH_ON_TOP: assert property ((!ENCODE && fifo_bus.wr_valid) |->
                                      ($past(!CS_N && !BE_N[3]) && (CS_N || BE_N[3])))
        else $error("FIFO push without top lane release");
    AST_NO_LOW_ADV: assert property ((!ENCODE && $past(CS_N || BE_N[3])) |-> !fifo_bus.wr_valid)
        else $error("FIFO advanced by lower lanes");
    AST_IDX_STEP: assert property ((half_rel && !$past(wr_rise)) |=>
                                   ireg_idx_reg == $past(ireg_idx_reg) + 16'h0001)
        else $error("Indirect index did not step");
    AST_IDX_HOLD: assert property ((!half_rel && !wr_rise) |=> $stable(ireg_idx_reg))
        else $error("Indirect index moved without cause");
    AST_ACK_FULL: assert property ((!CS_N && !WR_N && ADR == 2'h0 && !ENCODE && FIFO_FULL) |-> ACK_N)
        else $error("Acknowledge given on full FIFO");
    AST_ACK_EMPTY: assert property ((!CS_N && !RD_N && ADR == 2'h0 && ENCODE && FIFO_EMPTY) |-> ACK_N)
        else $error("Acknowledge given on empty FIFO");
    AST_WR_CAPTURE: assert property ((wr_rise && adr_reg == 2'h1 && lanes_reg == 4'hF) |=>
                                     ireg_idx_reg == $past(DATA_I[15:0]))
        else $error("Write data not taken at strobe rise");
    AST_LANE_KEEP: assert property ((wr_rise && adr_reg == 2'h0 && !lanes_reg[0]) |=>
                                    asm_reg[7:0] == $past(asm_reg[7:0]))
        else $error("Disabled byte lane overwritten");
    AST_ORDER_WORD: assert property ((host_push && wr_rise && lanes_reg[3]) |->
                                     fifo_bus.wr_data[31:24] == DATA_I[31:24])
        else $error("Top byte missing from pushed word");

    // Bus drive, acknowledge, lane select and FIFO flag checks
    AST_OE_ONLY_READ: assert property (DATA_OE |-> (!CS_N && !RD_N))
        else $error("Bus driven without read strobe");
    AST_OE_ON_READ: assert property ((!CS_N && !RD_N) |-> DATA_OE)
        else $error("Read strobe low but bus not driven");
    AST_ACK_NEEDS_STROBE: assert property (!ACK_N |-> (!RD_N || !WR_N))
        else $error("Acknowledge without strobe");
    AST_ACK_WR_REG: assert property ((!CS_N && !WR_N && ADR != 2'h0) |-> !ACK_N)
        else $error("Register write not acknowledged");
    AST_LANES_DESEL: assert property (CS_N |=> lanes_reg == 4'h0)
        else $error("Lane selects taken while deselected");
    AST_FLAGS_APART: assert property (FIFO_FULL |-> !FIFO_EMPTY)
        else $error("FIFO full and empty together");

    // FIFO advance checks
    AST_POP_ON_TOP: assert property ((ENCODE && fifo_bus.rd_ready) |->
                                     ($past(!CS_N && !BE_N[3]) && (CS_N || BE_N[3])))
        else $error("FIFO pop without top lane release");
    AST_NO_LOW_POP: assert property ((ENCODE && $past(CS_N || BE_N[3])) |-> !fifo_bus.rd_ready)
        else $error("FIFO popped by lower lanes");

    // Indirect register checks
    AST_HALF_NEEDS_LANE: assert property (half_rel |-> $past(!CS_N && !BE_N[1]))
        else $error("Index step without upper half lane");
    AST_WE_PULSE: assert property (IREG_WE |=> !IREG_WE)
        else $error("Indirect write longer than one cycle");
    AST_WE_AFTER_HALF: assert property (IREG_WE |-> $past(half_rel))
        else $error("Indirect write without half lane release");
    AST_WE_ADDR: assert property (IREG_WE |-> IREG_ADDR == $past(ireg_idx_reg))
        else $error("Indirect write to wrong index");
    AST_WE_STRB: assert property (IREG_WE |-> IREG_WSTRB != 2'h0)
        else $error("Indirect write with no lanes");
endmodule // hblap_host_port

// ===== verification/hblap_host_model.sv
`timescale 1ns/1ps
module hblap_host_model (
    input wire logic mclk,
    input wire logic ack_n,
    input wire logic [31:0] bus,
    output logic cs_n,
    output logic rd_n,
    output logic wr_n,
    output logic [3:0] be_n,
    output logic [1:0] adr,
    output logic [31:0] data_i,
    output int hung
);
    task automatic pins(input logic s, input logic l);
        cs_n <= s;
        rd_n <= l;
        wr_n <= l;
        be_n <= {4{l}};
        adr <= hblap_pkg::ADR_IADDR;
        data_i <= 32'hFFFF_FFFF;
    endtask
    task automatic ghost(input logic l);
        @(posedge mclk);
        pins(1'b1, l);
    endtask
    task automatic wait_ack();
        int n;
        n = 0;
        @(posedge mclk);
        while (ack_n !== 1'b0 && n < 64) begin
            @(posedge mclk);
            n++;
        end
        if (n == 64) hung++;
    endtask
    task automatic wr(input logic [1:0] a, input logic [3:0] b, input logic [31:0] d);
        @(posedge mclk);
        cs_n <= 1'b0;
        adr <= a;
        be_n <= b;
        data_i <= d;
        wr_n <= 1'b0;
        wait_ack();
        wr_n <= 1'b1;
        @(posedge mclk);
        be_n <= 4'hF;
        data_i <= ~d;
        @(posedge mclk);
    endtask
    task automatic rd(input logic [1:0] a, input logic [3:0] b, output logic [31:0] q);
        @(posedge mclk);
        cs_n <= 1'b0;
        adr <= a;
        be_n <= b;
        rd_n <= 1'b0;
        wait_ack();
        q = bus;
        rd_n <= 1'b1;
        @(posedge mclk);
        be_n <= 4'hF;
        repeat (2) @(posedge mclk);
    endtask
    initial begin
        hung = 0;
        pins(1'b1, 1'b1);
    end
endmodule // hblap_host_model

// ===== verification/hblap_host_port_tb.sv
`timescale 1ns/1ps
module hblap_host_port_tb;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic enc = 1'b0;
    logic tx_v = 1'b0;
    logic rx_rdy = 1'b0;
    logic [31:0] tx_d = 32'h0;
    logic [33:0] we_log = 34'h0;
    logic doe, ack_n, ffull, fempty, tx_rdy, rx_v, iwe, cs_n, rd_n, wr_n;
    logic [3:0] be_n;
    logic [1:0] adr, iwstrb;
    logic [31:0] din, dout, rx_d, q;
    logic [15:0] iaddr, iwdata;
    int errors = 0;
    int n_checks = 0;
    int we_n = 0;
    int hung;
    wire [31:0] dbus = doe ? dout : 32'hZZZZ_ZZZZ;
    always #5 mclk = ~mclk;
    always @(posedge mclk) begin
        if (iwe === 1'b1) begin
            we_n <= we_n + 1;
            we_log <= {iaddr, iwstrb, iwdata};
        end
    end
    hblap_host_port DUT (.MCLK(mclk), .NRST(nrst), .CS_N(cs_n), .RD_N(rd_n), .WR_N(wr_n), .BE_N(be_n),
        .ADR(adr), .DATA_I(din), .DATA_O(dout), .DATA_OE(doe), .ACK_N(ack_n), .ENCODE(enc),
        .FIFO_FULL(ffull), .FIFO_EMPTY(fempty), .CORE_TX_DATA(tx_d), .CORE_TX_VALID(tx_v),
        .CORE_TX_READY(tx_rdy), .CORE_RX_DATA(rx_d), .CORE_RX_VALID(rx_v), .CORE_RX_READY(rx_rdy),
        .IREG_ADDR(iaddr), .IREG_WDATA(iwdata), .IREG_WSTRB(iwstrb), .IREG_WE(iwe), .IREG_RDATA(16'h5A3C));
    hblap_host_model host (.mclk(mclk), .ack_n(ack_n), .bus(dbus), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
        .be_n(be_n), .adr(adr), .data_i(din), .hung(hung));
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        chk(hung, 0);
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic pop_rx(input logic [31:0] e);
        repeat (2) @(posedge mclk);
        #1;
        chk({rx_v, rx_d}, {1'b1, e});
        @(posedge mclk);
        rx_rdy <= 1'b1;
        @(posedge mclk);
        rx_rdy <= 1'b0;
    endtask
    task automatic push_tx(input logic [31:0] d);
        @(posedge mclk);
        tx_d <= d;
        tx_v <= 1'b1;
        @(posedge mclk);
        tx_v <= 1'b0;
    endtask
    task automatic t_cs();
        chk({fempty, ffull, iaddr}, 18'h20000);
        host.ghost(1'b0);
        #1;
        chk({doe, ack_n}, 2'b01);
        host.ghost(1'b1);
        repeat (2) @(posedge mclk);
        #1;
        chk(iaddr, 0);
        $display("select test done");
    endtask
    task automatic t_dec();
        host.wr(2'h0, 4'hC, 32'h0000_BBAA);
        #1;
        chk(rx_v, 0);
        host.wr(2'h0, 4'h3, 32'hDDCC_0000);
        for (int i = 0; i < 4; i++) host.wr(2'h0, ~(4'h1 << i), 32'h13121110 & (32'hFF << 8 * i));
        pop_rx(32'hDDCC_BBAA);
        pop_rx(32'h1312_1110);
        $display("decode test done");
    endtask
    task automatic t_full();
        for (int i = 0; i < 8; i++) host.wr(2'h0, 4'h0, 32'hA0 + i);
        #1;
        chk(ffull, 1);
        fork
            host.wr(2'h0, 4'h0, 32'hA8);
            begin
                repeat (4) @(posedge mclk);
                #1;
                chk(ack_n, 1);
            end
        join_any
        for (int i = 0; i < 9; i++) pop_rx(32'hA0 + i);
        wait fork;
        #1;
        chk(fempty, 1);
        $display("full test done");
    endtask
    task automatic t_enc();
        enc <= 1'b1;
        push_tx(32'hC1C1_0001);
        push_tx(32'hC2C2_0002);
        chk(tx_rdy, 1);
        host.rd(hblap_pkg::ADR_DATA, 4'h0, q);
        chk(q, 32'hC1C1_0001);
        host.rd(hblap_pkg::ADR_DATA, 4'hC, q);
        chk(q[15:0], 16'h0002);
        host.rd(hblap_pkg::ADR_DATA, 4'h3, q);
        chk({fempty, q[31:16]}, 17'h1C2C2);
        fork
            host.rd(hblap_pkg::ADR_DATA, 4'h0, q);
            begin
                repeat (4) @(posedge mclk);
                #1;
                chk(ack_n, 1);
                push_tx(32'hC3C3_0003);
            end
        join
        chk(q, 32'hC3C3_0003);
        $display("encode test done");
    endtask
    task automatic t_ind();
        host.wr(hblap_pkg::ADR_IADDR, 4'hC, 32'h1234);
        host.wr(hblap_pkg::ADR_IADDR, 4'hE, 32'hFF77);
        #1;
        chk(iaddr, 16'h1277);
        host.wr(hblap_pkg::ADR_IDATA, 4'hE, 32'h55);
        #1;
        chk({we_n[3:0], iaddr}, 20'h01277);
        host.wr(hblap_pkg::ADR_IDATA, 4'hD, 32'hAA00);
        repeat (2) @(posedge mclk);
        #1;
        chk({we_log, iaddr}, {16'h1277, 2'h3, 16'hAA55, 16'h1278});
        host.rd(hblap_pkg::ADR_IADDR, 4'hC, q);
        chk(q, 32'h0000_1278);
        host.rd(hblap_pkg::ADR_IDATA, 4'hE, q);
        chk({q, iaddr}, {32'h0000_5A3C, 16'h1278});
        $display("indirect test done");
    endtask
    initial begin
        repeat (5) @(posedge mclk);
        nrst <= 1'b1;
        t_cs();
        t_dec();
        t_full();
        t_enc();
        t_ind();
        give_verdict();
    end
    initial begin
        repeat (20000) @(posedge mclk);
        errors++;
        give_verdict();
    end
endmodule // hblap_host_port_tb
